// >>> core/ccrm_sync.sv
// Two-flop synchroniser for the loss-of-signal pin
`timescale 1ns/1ps
`default_nettype none

module ccrm_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic meta_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

// >>> core/ccrm_top.sv
// Receive clear-channel monitor: AXI4-Lite registers, change latches, interrupt, alarm insert
`timescale 1ns/1ps
`default_nettype none
`include "ccrm_regs.svh"

module ccrm_top (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  input  wire logic [`CCRM_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output var  logic [1:0]                s_axi_bresp,
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  input  wire logic [`CCRM_ADDR_W-1:0]   s_axi_araddr,
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output var  logic [31:0]               s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  input  wire logic                      signal_loss_input_pin,
  input  wire logic                      unframed_all_ones_in,
  input  wire logic                      rx_data_in,
  output var  logic                      rx_data_out,
  output var  logic                      alarm_insert_active,
  output var  logic                      irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic                    loss_sync;
  ccrm_pkg::ccrm_reg_t     ctrl_r;
  ccrm_pkg::ccrm_reg_t     live_r;
  ccrm_pkg::ccrm_reg_t     live_nxt;
  ccrm_pkg::ccrm_reg_t     latch_r;
  ccrm_pkg::ccrm_reg_t     changed;
  ccrm_pkg::ccrm_reg_t     clear_vec;
  ccrm_pkg::ccrm_reg_t     irq_en_r;
  ccrm_pkg::ccrm_reg_t     wr_val;
  logic [`CCRM_ADDR_W-1:0] aw_addr_r;
  logic [31:0]             w_data_r;
  logic [3:0]              w_strb_r;
  logic                    aw_got_r;
  logic                    aw_got_nxt;
  logic                    w_got_r;
  logic                    w_got_nxt;
  logic                    bvalid_nxt;
  logic                    rvalid_nxt;
  logic                    aw_hs;
  logic                    w_hs;
  logic                    ar_hs;
  logic                    wr_go;
  logic                    wr_ctrl;
  logic                    wr_latch;
  logic                    wr_irq_en;
  logic                    wr_clear;
  logic                    wr_mapped;
  logic                    alarm_nxt;
  logic                    irq_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  ccrm_sync u_loss_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (signal_loss_input_pin),
    .sync_out (loss_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write channel handshake

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs  = s_axi_wvalid & s_axi_wready;
  assign wr_go = aw_got_r & w_got_r & ~s_axi_bvalid;

  always_comb
  begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    bvalid_nxt = s_axi_bvalid;
    if (aw_hs)
    begin
      aw_got_nxt = 1'b1;
    end
    if (w_hs)
    begin
      w_got_nxt = 1'b1;
    end
    if (wr_go)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
    end
    else
    begin
      aw_got_r      <= aw_got_nxt;
      w_got_r       <= w_got_nxt;
      s_axi_awready <= ~aw_got_nxt & ~bvalid_nxt;
      s_axi_wready  <= ~w_got_nxt & ~bvalid_nxt;
      s_axi_bvalid  <= bvalid_nxt;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_r <= '0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_hs)
      begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  assign wr_ctrl   = wr_go && (aw_addr_r == `CCRM_CTRL_OFS);
  assign wr_latch  = wr_go && (aw_addr_r == `CCRM_LATCH_OFS);
  assign wr_irq_en = wr_go && (aw_addr_r == `CCRM_IRQ_EN_OFS);
  assign wr_clear  = wr_go && (aw_addr_r == `CCRM_CLEAR_OFS);
  assign wr_mapped = wr_ctrl || wr_latch || wr_irq_en || wr_clear
                     || (aw_addr_r == `CCRM_LIVE_OFS);

  // Only the two low byte lanes carry register bits
  assign wr_val = {w_strb_r[1] ? w_data_r[15:8] : 8'h00,
                   w_strb_r[0] ? w_data_r[7:0]  : 8'h00};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bresp <= `CCRM_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bresp <= wr_mapped ? `CCRM_RESP_OKAY : `CCRM_RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and enable registers

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= `CCRM_CTRL_RST;
    end
    else if (wr_ctrl)
    begin
      ctrl_r <= (ctrl_r & ~{{8{w_strb_r[1]}}, {8{w_strb_r[0]}}} | wr_val)
                & `CCRM_CTRL_MASK;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_en_r <= `CCRM_IRQ_EN_RST;
    end
    else if (wr_irq_en)
    begin
      irq_en_r <= (irq_en_r & ~{{8{w_strb_r[1]}}, {8{w_strb_r[0]}}} | wr_val)
                  & `CCRM_EVENT_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live status and change latches

  always_comb
  begin
    live_nxt                     = `CCRM_LIVE_RST;
    live_nxt[`CCRM_ALL_ONES_BIT] = unframed_all_ones_in;
    live_nxt[`CCRM_LOSS_BIT]     = loss_sync;
  end

  // Either direction of change counts
  assign changed   = (live_nxt ^ live_r) & `CCRM_EVENT_MASK;
  assign clear_vec = (wr_latch || wr_clear) ? (wr_val & `CCRM_EVENT_MASK) : 16'h0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      live_r <= `CCRM_LIVE_RST;
    end
    else
    begin
      live_r <= live_nxt;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      latch_r <= `CCRM_LATCH_RST;
    end
    else
    begin
      latch_r <= (latch_r & ~clear_vec) | changed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt

  assign irq_nxt = |(latch_r & irq_en_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Downstream alarm insertion

  assign alarm_nxt = ctrl_r[`CCRM_MANUAL_BIT]
                     | (live_r[`CCRM_LOSS_BIT] & ~ctrl_r[`CCRM_AUTO_DIS_BIT]);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alarm_insert_active <= 1'b0;
      rx_data_out         <= 1'b0;
    end
    else
    begin
      alarm_insert_active <= alarm_nxt;
      rx_data_out         <= alarm_nxt | rx_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  assign ar_hs = s_axi_arvalid & s_axi_arready;

  always_comb
  begin
    rvalid_nxt = s_axi_rvalid;
    if (ar_hs)
    begin
      rvalid_nxt = 1'b1;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b0;
    end
    else
    begin
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_arready <= ~rvalid_nxt;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CCRM_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axi_rresp <= `CCRM_RESP_OKAY;
      unique case (s_axi_araddr)
        `CCRM_CTRL_OFS:   s_axi_rdata <= {16'h0000, ctrl_r};
        `CCRM_LIVE_OFS:   s_axi_rdata <= {16'h0000, live_r};
        `CCRM_LATCH_OFS:  s_axi_rdata <= {16'h0000, latch_r};
        `CCRM_IRQ_EN_OFS: s_axi_rdata <= {16'h0000, irq_en_r};
        `CCRM_CLEAR_OFS:  s_axi_rdata <= 32'h0000_0000;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `CCRM_RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_MANUAL_INSERT: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ctrl_r[`CCRM_MANUAL_BIT] |=> (alarm_insert_active && rx_data_out))
    else $error("manual alarm insert did not force output");

  AST_AUTO_INSERT: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (live_r[`CCRM_LOSS_BIT] && !ctrl_r[`CCRM_AUTO_DIS_BIT]) |=> alarm_insert_active)
    else $error("loss of signal did not insert alarm");

  AST_NO_INSERT: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!ctrl_r[`CCRM_MANUAL_BIT] && (!live_r[`CCRM_LOSS_BIT] || ctrl_r[`CCRM_AUTO_DIS_BIT]))
    |=> !alarm_insert_active)
    else $error("alarm inserted without cause");

  AST_ALL_ONES_LIVE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (unframed_all_ones_in != live_r[`CCRM_ALL_ONES_BIT])
    |=> ($changed(live_r[`CCRM_ALL_ONES_BIT]) && latch_r[`CCRM_ALL_ONES_BIT]))
    else $error("all-ones live status wrong");

  AST_LOSS_LIVE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    signal_loss_input_pin [*3] |=> live_r[`CCRM_LOSS_BIT])
    else $error("loss live status does not follow pin");

  AST_ALL_ONES_LATCH: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $changed(live_r[`CCRM_ALL_ONES_BIT]) |-> latch_r[`CCRM_ALL_ONES_BIT])
    else $error("all-ones change not latched");

  AST_LOSS_LATCH: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $changed(live_r[`CCRM_LOSS_BIT]) |-> latch_r[`CCRM_LOSS_BIT])
    else $error("loss change not latched");

  AST_ALL_ONES_IRQ: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (latch_r[`CCRM_ALL_ONES_BIT] && irq_en_r[`CCRM_ALL_ONES_BIT]) |=> irq)
    else $error("all-ones interrupt missing");

  AST_LOSS_IRQ: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (latch_r[`CCRM_LOSS_BIT] && irq_en_r[`CCRM_LOSS_BIT]) |=> irq)
    else $error("loss interrupt missing");

  AST_IRQ_QUIET: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((latch_r & irq_en_r) == 16'h0000) |=> !irq)
    else $error("interrupt without enabled latch");

  AST_ALARM_ONES: assert property (
    @(posedge aclk) disable iff (!aresetn)
    alarm_insert_active |-> rx_data_out)
    else $error("alarm active but data not all ones");

  AST_SET_WINS: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((changed & clear_vec) != 16'h0000) |=> ((latch_r & $past(changed)) == $past(changed)))
    else $error("clear beat a new change");

  AST_LATCH_HOLDS: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (latch_r[`CCRM_ALL_ONES_BIT] && !clear_vec[`CCRM_ALL_ONES_BIT])
    |=> latch_r[`CCRM_ALL_ONES_BIT])
    else $error("latch dropped without clear");

endmodule

`default_nettype wire

// >>> dv/ccrm_line_model.sv
// Line interface and frame processor stand-in for the receive monitor
`timescale 1ns/1ps
`default_nettype none

module ccrm_line_model (
  input  wire logic aclk,
  input  wire logic loss_req,
  input  wire logic ones_req,
  output var  logic los_pin,
  output var  logic ones_det,
  output var  logic line_bit
);
  logic [2:0] lfsr_r;

  initial
  begin
    lfsr_r   = 3'h1;
    los_pin  = 1'b0;
    ones_det = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Levels follow requests; data never repeats a fixed value
  always @(posedge aclk)
  begin
    los_pin  <= loss_req;
    ones_det <= ones_req;
    lfsr_r   <= {lfsr_r[1:0], lfsr_r[2] ^ lfsr_r[1]};
  end

  assign line_bit = lfsr_r[0];
endmodule

`default_nettype wire

// >>> dv/ccrm_top_test.sv
// Self-checking bench for the receive clear-channel monitor
`timescale 1ns/1ps
`default_nettype none

module ccrm_top_test;
  logic        aclk, aresetn, loss_req, ones_req, los_pin, ones_det, line_bit;
  logic        awvalid, wvalid, bready, arvalid, rready, prev;
  logic        awready, wready, bvalid, arready, rvalid, rx_out, alarm, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  int          bad_count, compares;
  // Row: manual, auto disable, loss, expected alarm
  logic [3:0]  rows [8] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h9, 4'hB, 4'hD, 4'hF};

  ccrm_top u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .signal_loss_input_pin(los_pin), .unframed_all_ones_in(ones_det),
    .rx_data_in(line_bit), .rx_data_out(rx_out), .alarm_insert_active(alarm), .irq(irq)
  );

  ccrm_line_model u_line (
    .aclk(aclk), .loss_req(loss_req), .ones_req(ones_req),
    .los_pin(los_pin), .ones_det(ones_det), .line_bit(line_bit)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    bready  <= 1'b1;
    for (i = 0; i < 40 && bvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
    if (i >= 40)
    begin
      bad_count++;
      final_report();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    int i;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (i = 0; i < 40 && rvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(rdata, ev);
    chk(32'(rresp), 32'(er));
    if (i >= 40)
    begin
      bad_count++;
      final_report();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  initial
  begin
    {aresetn, loss_req, ones_req, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    awaddr    = 8'h00;
    araddr    = 8'h00;
    wdata     = 32'h0;
    bad_count = 0;
    compares  = 0;
    tick(5);
    aresetn <= 1'b1;
    // Reset values, unmapped place, reserved and read-only bits
    rd(8'h20, 32'h0, 2'h0);
    rd(8'h24, 32'h0, 2'h0);
    rd(8'h28, 32'h0, 2'h0);
    rd(8'h2C, 32'h0, 2'h0);
    rd(8'h30, 32'h0, 2'h0);
    rd(8'h34, 32'h0, 2'h2);
    wr(8'h34, 32'h1, 2'h2);
    wr(8'h20, 32'hFFFFFFFF, 2'h0);
    rd(8'h20, 32'h1800, 2'h0);
    wr(8'h24, 32'hFFFF, 2'h0);
    rd(8'h24, 32'h0, 2'h0);
    // Alarm insertion table
    foreach (rows[k])
    begin
      @(posedge aclk);
      loss_req <= rows[k][1];
      wr(8'h20, {19'h0, rows[k][3:2], 11'h0}, 2'h0);
      tick(6);
      rd(8'h24, {31'h0, rows[k][1]}, 2'h0);
      chk(32'(alarm), 32'(rows[k][0]));
      @(posedge aclk);
      prev = line_bit;
      #1 chk(32'(rx_out), rows[k][0] ? 32'h1 : 32'(prev));
    end
    // Change latches and interrupt
    wr(8'h20, 32'h0, 2'h0);
    @(posedge aclk);
    loss_req <= 1'b0;
    tick(6);
    wr(8'h30, 32'h0101, 2'h0);
    rd(8'h28, 32'h0, 2'h0);
    wr(8'h2C, 32'h0001, 2'h0);
    @(posedge aclk);
    ones_req <= 1'b1;
    tick(6);
    rd(8'h24, 32'h0100, 2'h0);
    rd(8'h28, 32'h0100, 2'h0);
    chk(32'(irq), 32'h0);
    wr(8'h2C, 32'h0101, 2'h0);
    tick(2);
    chk(32'(irq), 32'h1);
    wr(8'h30, 32'h0, 2'h0);
    rd(8'h28, 32'h0100, 2'h0);
    wr(8'h28, 32'h0100, 2'h0);
    tick(2);
    chk(32'(irq), 32'h0);
    // Clear lands on the same edge as the all-ones fall
    fork
      wr(8'h28, 32'h0100, 2'h0);
      begin
        tick(1);
        ones_req <= 1'b0;
      end
    join
    tick(6);
    rd(8'h28, 32'h0100, 2'h0);
    wr(8'h28, 32'h0100, 2'h0);
    @(posedge aclk);
    loss_req <= 1'b1;
    tick(6);
    rd(8'h28, 32'h0001, 2'h0);
    chk(32'(irq), 32'h1);
    chk(32'(alarm), 32'h1);
    wr(8'h2C, 32'h0100, 2'h0);
    tick(2);
    chk(32'(irq), 32'h0);
    wr(8'h30, 32'h0001, 2'h0);
    @(posedge aclk);
    loss_req <= 1'b0;
    tick(6);
    rd(8'h28, 32'h0001, 2'h0);
    // Reset in mid-run
    wr(8'h20, 32'h1000, 2'h0);
    @(posedge aclk);
    aresetn <= 1'b0;
    tick(3);
    aresetn <= 1'b1;
    tick(2);
    chk(32'(alarm), 32'h0);
    chk(32'(irq), 32'h0);
    rd(8'h20, 32'h0, 2'h0);
    rd(8'h28, 32'h0, 2'h0);
    final_report();
  end
endmodule

`default_nettype wire

// >>> include/ccrm_pkg.sv
// Types shared by the receive monitor modules
package ccrm_pkg;

  typedef logic [15:0] ccrm_reg_t;

  typedef enum logic [1:0] {
    CCRM_RESP_OKAY   = 2'h0,
    CCRM_RESP_SLVERR = 2'h2
  } ccrm_resp_t;

endpackage

// >>> include/ccrm_regs.svh
// Register offsets, field positions, reset values and bus codes of the receive monitor
//
// Overview of operation
// - Manual alarm insert bit set forces alarm signal onto downstream data.
// - Loss of signal inserts alarm unless automatic insertion is disabled.
// - Live status shows the unframed all-ones detector level.
// - Live status shows the synchronised loss-of-signal pin level.
// - Any change of the all-ones status sets its change latch.
// - Any change of the loss-of-signal status sets its change latch.
// - All-ones latch with its enable set raises the interrupt.
// - Loss-of-signal latch with its enable set raises the interrupt.
// - While alarm is inserted the downstream data are all ones.
`ifndef CCRM_REGS_SVH
`define CCRM_REGS_SVH

`define CCRM_ADDR_W        8
`define CCRM_CTRL_OFS      8'h20
`define CCRM_LIVE_OFS      8'h24
`define CCRM_LATCH_OFS     8'h28
`define CCRM_IRQ_EN_OFS    8'h2C
`define CCRM_CLEAR_OFS     8'h30

`define CCRM_MANUAL_BIT    12
`define CCRM_AUTO_DIS_BIT  11
`define CCRM_ALL_ONES_BIT  8
`define CCRM_LOSS_BIT      0

`define CCRM_CTRL_MASK     16'h1800
`define CCRM_EVENT_MASK    16'h0101
`define CCRM_CTRL_RST      16'h0000
`define CCRM_LIVE_RST      16'h0000
`define CCRM_LATCH_RST     16'h0000
`define CCRM_IRQ_EN_RST    16'h0000

`define CCRM_RESP_OKAY     2'h0
`define CCRM_RESP_SLVERR   2'h2

`endif
